// File: lbc_cycle_ctrl.sv
// Functional notes
// - bus cycles timed by divided tick, max 66 MHz
// - burst chip select lasts 1+wait+beats cycles
// - burst acknowledge lasts exactly the beat count
// - long burst only with enable, select, internal burst
// - burst acknowledge is an output marking beats
// - wait states 0 to 65535 from two fields
// - acknowledge starts within wait+1 after chip select
// - burst data moves on bus clock edges
// - one-cycle start strobe just before chip select
// - burst direction one cycle before and after select
// - turnaround of dead cycles plus one
// - multiplexed select 2+wait, ended early by acknowledge
// - latch enable one cycle with address, bank, size
// - after select, shared lines carry write data
// - write data held after select negates
// - direction set before latch, released after select
// - output enable follows chip select on reads
// - multiplexed read data sampled at select negation
// - burst address driven one cycle before select
`include "lbc_map.svh"
`default_nettype none

module lbc_cycle_ctrl
  import lbc_pkg::*;
#(
  parameter logic [7:0] PCI_DIV = 8'(`LBC_PCI_DIV)
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire lbc_req_t i_req,
  input wire logic [31:0] i_beat_wdata,
  output lbc_word_t o_beat,
  output lbc_word_t o_rsp,
  output logic o_busy,
  input wire lbc_pin_in_t i_pin,
  output lbc_pins_t o_pin
);

  localparam lbc_pins_t PINS_IDLE = '{
    cs_b: 1'h1,
    ts_b: 1'h1,
    ale: 1'h0,
    oe_b: 1'h1,
    rnw: `LBC_RNW_IDLE,
    ack_b: 1'h1,
    addr: 32'h0000_0000,
    ad_out: 32'h0000_0000,
    ad_oe: 1'h0,
    transfer_size: 2'h0,
    bank: 2'h0
  };

  localparam lbc_pin_in_t PIN_IN_IDLE = '{
    ack_b: 1'h1,
    ad_in: 32'h0000_0000
  };

  localparam lbc_word_t WORD_IDLE = '{
    valid: 1'h0,
    data: 32'h0000_0000
  };

  localparam lbc_req_t REQ_IDLE = '{
    burst_mode: 1'h0,
    rnw: 1'h1,
    addr: 32'h0000_0000,
    bank: 2'h0,
    wdata: 32'h0000_0000,
    data_size: 2'h0,
    wait_count_primary: 8'h00,
    wait_count_extra: 8'h00,
    dead_cycle_count: 4'h0,
    burst_enable_per_cs: 1'h0,
    long_burst_select: 1'h0,
    internal_system_bus_burst: 1'h0
  };

  localparam lbc_st_t ST_RST = '{
    state: LBC_IDLE,
    div: 8'h00,
    cnt: 16'h0000,
    req: REQ_IDLE,
    pins: PINS_IDLE,
    s1: PIN_IN_IDLE,
    s2: PIN_IN_IDLE,
    s3: PIN_IN_IDLE,
    filt: PIN_IN_IDLE,
    rsp: WORD_IDLE,
    beat: WORD_IDLE
  };

  // a change counts once the second and third sync stages agree
  function automatic lbc_pin_in_t agree(input lbc_pin_in_t s2,
                                        input lbc_pin_in_t s3,
                                        input lbc_pin_in_t f);
    agree = (s2 & s3) | (f & (s2 ^ s3));
  endfunction

  // beats per word shift for the data size
  function automatic logic [1:0] size_shift(input logic [1:0] ds);
    case (ds)
      `LBC_DS_8: size_shift = 2'h2;
      `LBC_DS_16: size_shift = 2'h1;
      default: size_shift = 2'h0;
    endcase
  endfunction

  // beats of one cache line: 4^lb * 2 * (32 / data size)
  function automatic logic [5:0] burst_beats(input lbc_req_t r);
    logic lb;
    lb = r.burst_enable_per_cs & r.long_burst_select &
         r.internal_system_bus_burst;
    burst_beats = (`LBC_BASE_BEATS << size_shift(r.data_size))
                  << (lb ? `LBC_LONG_SHIFT : 2'h0);
  endfunction

  // wait state count formed from its two fields
  function automatic logic [15:0] wait_states(input lbc_req_t r);
    wait_states = {r.wait_count_primary, r.wait_count_extra};
  endfunction

  // turnaround length in bus cycles, less one
  function automatic logic [15:0] dead_cycles(input lbc_req_t r);
    dead_cycles = {12'h000, r.dead_cycle_count};
  endfunction

  lbc_st_t q;
  lbc_st_t d;
  logic tick;
  logic ack_seen;
  logic go_beat;
  logic [15:0] ws;
  logic [5:0] beats;

  always_comb begin
    d = q;
    go_beat = 1'b0;
    ws = wait_states(q.req);
    beats = burst_beats(q.req);
    tick = (q.div == 8'h00);
    d.div = tick ? PCI_DIV - 8'h01 : q.div - 8'h01;
    d.s1 = i_pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = agree(q.s2, q.s3, q.filt);
    ack_seen = ~q.filt.ack_b;
    d.rsp.valid = 1'b0;
    d.beat.valid = 1'b0;
    if (tick) begin
      case (q.state)
        LBC_IDLE: begin
          if (i_req_valid) begin
            d.req = i_req;
            d.state = LBC_SETUP;
            d.pins.rnw = i_req.rnw;
            if (i_req.burst_mode) begin
              d.pins.ts_b = 1'b0;
              d.pins.addr = i_req.addr;
              d.pins.transfer_size = i_req.data_size;
              d.pins.bank = i_req.bank;
            end
          end
        end
        LBC_SETUP: begin
          d.pins.ts_b = 1'b1;
          if (q.req.burst_mode) begin
            d.state = LBC_LEAD;
            d.pins.cs_b = 1'b0;
            d.pins.oe_b = ~q.req.rnw;
            d.cnt = ws;
          end else begin
            d.state = LBC_ALE;
            d.pins.ale = 1'b1;
            d.pins.ts_b = 1'b0;
            d.pins.ad_oe = 1'b1;
            d.pins.ad_out = {q.req.data_size, q.req.bank, 3'h0,
                             q.req.addr[24:0]};
            d.pins.transfer_size = q.req.data_size;
            d.pins.bank = q.req.bank;
          end
        end
        LBC_ALE: begin
          d.state = LBC_MUXCS;
          d.pins.ale = 1'b0;
          d.pins.ts_b = 1'b1;
          d.pins.cs_b = 1'b0;
          d.pins.oe_b = ~q.req.rnw;
          d.pins.ad_oe = ~q.req.rnw;
          d.pins.ad_out = q.req.rnw ? 32'h0000_0000 : q.req.wdata;
          d.cnt = ws + `LBC_MUX_CS_EXTRA;
        end
        LBC_MUXCS: begin
          if (q.cnt == 16'h0000 || ack_seen) begin
            d.state = LBC_TURN;
            d.pins.cs_b = 1'b1;
            d.pins.oe_b = 1'b1;
            d.rsp.valid = 1'b1;
            d.rsp.data = q.req.rnw ? q.filt.ad_in : 32'h0000_0000;
            d.cnt = dead_cycles(q.req);
          end else begin
            d.cnt = q.cnt - 16'h0001;
          end
        end
        LBC_LEAD: begin
          if (q.cnt == 16'h0000) begin
            go_beat = 1'b1;
          end else begin
            d.state = LBC_WAIT;
            d.cnt = q.cnt - 16'h0001;
          end
        end
        LBC_WAIT: begin
          if (q.cnt == 16'h0000) begin
            go_beat = 1'b1;
          end else begin
            d.cnt = q.cnt - 16'h0001;
          end
        end
        LBC_BEAT: begin
          if (q.req.rnw) begin
            d.beat.valid = 1'b1;
            d.beat.data = q.filt.ad_in;
            d.rsp.data = q.filt.ad_in;
          end
          if (q.cnt == 16'h0000) begin
            d.state = LBC_TURN;
            d.pins.cs_b = 1'b1;
            d.pins.ack_b = 1'b1;
            d.pins.oe_b = 1'b1;
            d.rsp.valid = 1'b1;
            // a write reports the last word it sent
            if (!q.req.rnw) begin
              d.rsp.data = q.beat.data;
            end
            d.cnt = dead_cycles(q.req);
          end else begin
            d.cnt = q.cnt - 16'h0001;
            if (!q.req.rnw) begin
              d.beat.valid = 1'b1;
              d.beat.data = i_beat_wdata;
              d.pins.ad_out = i_beat_wdata;
            end
          end
        end
        LBC_TURN: begin
          d.pins.rnw = `LBC_RNW_IDLE;
          d.pins.ad_oe = 1'b0;
          d.pins.ad_out = 32'h0000_0000;
          d.pins.addr = 32'h0000_0000;
          if (q.cnt == 16'h0000) begin
            d.state = LBC_IDLE;
          end else begin
            d.cnt = q.cnt - 16'h0001;
          end
        end
        default: begin
          d = ST_RST;
        end
      endcase
      if (go_beat) begin
        d.state = LBC_BEAT;
        d.pins.ack_b = 1'b0;
        d.cnt = {10'h000, beats - 6'h01};
        if (!q.req.rnw) begin
          d.pins.ad_oe = 1'b1;
          d.pins.ad_out = i_beat_wdata;
          d.beat.valid = 1'b1;
          d.beat.data = i_beat_wdata;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign o_req_ready = (q.state == LBC_IDLE) && tick;
  assign o_busy = (q.state != LBC_IDLE);
  assign o_beat = q.beat;
  assign o_rsp = q.rsp;
  assign o_pin = q.pins;

endmodule

`default_nettype wire

// File: lbc_cycle_ctrl_assertions.sv
`default_nettype none
module lbc_cycle_ctrl_assertions
  import lbc_pkg::*;
#(
  parameter logic [7:0] PCI_DIV = 8'h04
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire lbc_req_t i_req,
  input wire lbc_word_t o_rsp,
  input wire lbc_pins_t o_pin,
  input wire lbc_pin_in_t i_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  lbc_req_t r_q;
  logic [31:0] ak_q, tl_q, bt;
  logic [31:0] cs_q, ad, bw, mw;
  logic [15:0] ws;
  logic ai_q;
  logic lb;
  assign lb = r_q.burst_enable_per_cs & r_q.long_burst_select &
    r_q.internal_system_bus_burst;
  assign bt = ((32'h0000_0008 >> r_q.data_size) << (2 * lb)) * PCI_DIV;
  assign ws = {r_q.wait_count_primary, r_q.wait_count_extra};
  assign ad = (32'(ws) + 32'h0000_0001) * 32'(PCI_DIV);
  assign bw = ad + bt;
  assign mw = (32'(ws) + 32'h0000_0002) * 32'(PCI_DIV);
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_q <= '0;
      ak_q <= '0;
      tl_q <= '0;
      cs_q <= '0;
      ai_q <= 1'b0;
    end else begin
      cs_q <= o_pin.cs_b ? 32'h0 : cs_q + 32'h1;
      ai_q <= o_pin.cs_b ? 1'b0 : (ai_q | ~i_pin.ack_b);
      if (i_req_valid && o_req_ready) r_q <= i_req;
      ak_q <= o_pin.ack_b ? 32'h0 : ak_q + 32'h1;
      tl_q <= o_pin.ts_b ? 32'h0 : tl_q + 32'h1;
    end
  end
  a_ack_width: assert property (
    $rose(o_pin.ack_b) |-> ak_q == bt) else $error("ack width");
  a_ack_in_cs: assert property (
    !o_pin.ack_b |-> !o_pin.cs_b) else $error("ack outside cs");
  a_ts_width: assert property (
    $rose(o_pin.ts_b) |-> tl_q == 32'(PCI_DIV)) else $error("ts width");
  a_cs_after_ts: assert property (
    $fell(o_pin.cs_b) |-> $rose(o_pin.ts_b)) else $error("ts to cs");
  a_rw_setup: assert property (
    $fell(o_pin.cs_b) |-> $stable(o_pin.rnw) && o_pin.rnw == r_q.rnw)
    else $error("rw setup");
  a_rw_hold: assert property (
    $rose(o_pin.cs_b) |-> (o_pin.rnw == r_q.rnw) [*2])
    else $error("rw hold");
  a_ale_addr: assert property (
    o_pin.ale |-> o_pin.ad_oe && o_pin.ad_out ==
    {r_q.data_size, r_q.bank, 3'h0, r_q.addr[24:0]}) else $error("ale");
  a_mux_wdata: assert property (
    $fell(o_pin.cs_b) && !r_q.burst_mode && !o_pin.rnw |->
    o_pin.ad_oe && o_pin.ad_out == r_q.wdata) else $error("wdata");
  a_wdata_hold: assert property (
    $rose(o_pin.cs_b) && !r_q.burst_mode && !o_pin.rnw |->
    o_pin.ad_oe && o_pin.ad_out == r_q.wdata) else $error("wr hold");
  a_oe_follow: assert property (
    o_pin.oe_b == (o_pin.cs_b || !o_pin.rnw)) else $error("oe");
  a_cs_burst: assert property (
    $rose(o_pin.cs_b) && r_q.burst_mode |-> cs_q == bw)
    else $error("burst cs width");
  a_cs_mux: assert property (
    $rose(o_pin.cs_b) && !r_q.burst_mode && !ai_q |-> cs_q == mw)
    else $error("mux cs width");
  a_cs_mux_max: assert property (
    $rose(o_pin.cs_b) && !r_q.burst_mode |-> cs_q <= mw)
    else $error("mux cs too long");
  a_ack_delay: assert property (
    $fell(o_pin.ack_b) |-> cs_q <= ad) else $error("ack late");
  a_burst_addr: assert property (
    $fell(o_pin.cs_b) && r_q.burst_mode |-> o_pin.addr == r_q.addr &&
    $stable(o_pin.addr)) else $error("burst addr");
  c_long: cover property ($rose(o_pin.ack_b) && ak_q > 32'h0000_0010);
  c_mux_ack: cover property ($rose(o_pin.cs_b) && !r_q.burst_mode
    && ai_q);
  c_mux_rd: cover property ($rose(o_pin.cs_b) && !r_q.burst_mode
    && o_pin.rnw);
  c_mux_wr: cover property (o_pin.ale && !o_pin.rnw);
endmodule
`default_nettype wire

// File: lbc_cycle_ctrl_tb.sv
`default_nettype none
module lbc_cycle_ctrl_tb
  import lbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_b = 0, vld = 0, fast = 0, rdy, busy;
  lbc_req_t req = '0;
  logic [31:0] wd = 0, rd = 0;
  lbc_word_t beat, rsp;
  lbc_pins_t pin;
  lbc_pin_in_t pin_in;
  int mismatches = 0, compares = 0, cyc = 0;
  logic [32:0] q[$];
  always #2.5 clk = ~clk;
  lbc_cycle_ctrl #(.PCI_DIV(8'h04)) i_dut (.i_ref_clk(clk),
    .i_rst_b(rst_b), .i_req_valid(vld), .o_req_ready(rdy),
    .i_req(req), .i_beat_wdata(wd), .o_beat(beat), .o_rsp(rsp),
    .o_busy(busy), .i_pin(pin_in), .o_pin(pin));
  lbc_far_mem i_mem (.i_ref_clk(clk), .i_pin(pin), .i_fast(fast),
    .i_rd(rd), .o_pin(pin_in));
  task check(input logic [32:0] s, e, input string n);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task go(input logic bm, rw);
    logic [95:0] rr;
    logic lb;
    logic [31:0] d;
    int n;
    rr = {$urandom, $urandom, $urandom};
    req = rr[92:0];
    req.burst_mode = bm;
    req.rnw = rw;
    req.data_size = 2'($urandom_range(2));
    req.wait_count_primary = {7'h00, rr[95]};
    req.wait_count_extra &= 8'h03;
    fast = rr[94];
    wd = $urandom;
    rd = $urandom;
    lb = req.burst_enable_per_cs & req.long_burst_select &
      req.internal_system_bus_burst;
    n = (8 >> req.data_size) << (2 * lb);
    d = rw ? rd : (bm ? wd : 32'h0000_0000);
    if (bm) repeat (n) q.push_back({1'b0, d});
    q.push_back({1'b1, d});
    vld = 1;
    while (rdy !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    vld = 0;
    while (busy !== 1'b0) @(posedge clk) #1;
  endtask
  always @(posedge clk) begin
    #1;
    if (beat.valid === 1'b1)
      check({1'b0, beat.data}, q.pop_front(), "beat");
    if (rsp.valid === 1'b1)
      check({1'b1, rsp.data}, q.pop_front(), "rsp");
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      stop_test;
    end
  end
  initial begin
    void'($urandom(32'h8800_740a));
    repeat (5) @(posedge clk);
    #1 rst_b = 1;
    for (int i = 0; i < 24; i++) go(i[0], i[1]);
    repeat (4) @(posedge clk);
    check(33'(q.size()), 33'h0, "pending");
    stop_test;
  end
endmodule
bind lbc_cycle_ctrl lbc_cycle_ctrl_assertions #(.PCI_DIV(PCI_DIV)) i_chk (
  .i_ref_clk, .i_rst_b, .i_req_valid, .o_req_ready, .i_req, .o_rsp, .o_pin,
  .i_pin);
`default_nettype wire

// File: lbc_far_mem.sv
`default_nettype none
module lbc_far_mem
  import lbc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire lbc_pins_t i_pin,
  input wire logic i_fast,
  input wire logic [31:0] i_rd,
  output wire lbc_pin_in_t o_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] junk_q = 32'h5a5a_5a5a;
  // unselected lines show a pattern that changes every cycle
  always @(posedge i_ref_clk) junk_q <= ~junk_q;
  // read data while selected, early ack when prompt
  assign o_pin = {!(i_fast && !i_pin.cs_b),
    (!i_pin.cs_b && i_pin.rnw) ? i_rd : junk_q};
endmodule
`default_nettype wire

// File: lbc_map.svh
`ifndef LBC_MAP_SVH
`define LBC_MAP_SVH

// reference clock and fastest allowed local bus rate, in MHz
`define LBC_REF_MHZ 200
`define LBC_MAX_BUS_MHZ 66
// ref cycles per bus cycle, rounded up so the bus never exceeds its limit
`define LBC_PCI_DIV ((`LBC_REF_MHZ + `LBC_MAX_BUS_MHZ - 1) / `LBC_MAX_BUS_MHZ)

// data_size encodings
`define LBC_DS_8 2'h0
`define LBC_DS_16 2'h1
`define LBC_DS_32 2'h2

// beats of a short burst at 32-bit data size, and shift applied for a long one
`define LBC_BASE_BEATS 6'h02
`define LBC_LONG_SHIFT 2'h2

// count added to the wait states for the multiplexed chip select, which lasts two cycles beyond them
`define LBC_MUX_CS_EXTRA 16'h0001

// idle level of the read/write line (read)
`define LBC_RNW_IDLE 1'h1

`endif

// File: lbc_pkg.sv
`default_nettype none

package lbc_pkg;

  typedef enum logic [2:0] {
    LBC_IDLE  = 3'h0,
    LBC_SETUP = 3'h1,
    LBC_ALE   = 3'h2,
    LBC_LEAD  = 3'h3,
    LBC_WAIT  = 3'h4,
    LBC_BEAT  = 3'h5,
    LBC_MUXCS = 3'h6,
    LBC_TURN  = 3'h7
  } lbc_state_t;

  typedef struct packed {
    logic burst_mode;
    logic rnw;
    logic [31:0] addr;
    logic [1:0] bank;
    logic [31:0] wdata;
    logic [1:0] data_size;
    logic [7:0] wait_count_primary;
    logic [7:0] wait_count_extra;
    logic [3:0] dead_cycle_count;
    logic burst_enable_per_cs;
    logic long_burst_select;
    logic internal_system_bus_burst;
  } lbc_req_t;

  typedef struct packed {
    logic cs_b;
    logic ts_b;
    logic ale;
    logic oe_b;
    logic rnw;
    logic ack_b;
    logic [31:0] addr;
    logic [31:0] ad_out;
    logic ad_oe;
    logic [1:0] transfer_size;
    logic [1:0] bank;
  } lbc_pins_t;

  typedef struct packed {
    logic ack_b;
    logic [31:0] ad_in;
  } lbc_pin_in_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } lbc_word_t;

  typedef struct packed {
    lbc_state_t state;
    logic [7:0] div;
    logic [15:0] cnt;
    lbc_req_t req;
    lbc_pins_t pins;
    lbc_pin_in_t s1;
    lbc_pin_in_t s2;
    lbc_pin_in_t s3;
    lbc_pin_in_t filt;
    lbc_word_t rsp;
    lbc_word_t beat;
  } lbc_st_t;

endpackage

`default_nettype wire
